// >>> design/motion_pkg.sv
package motion_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int POS_W = 32;
	localparam int VEL_W = 32;
	localparam int TIME_W = 19;
	localparam int NUM_SEG = 4;
	localparam int DIV_W = 52;

	////////////////////////////////////////////////////////////////////////
	// Clock and ramp tick timing
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;
	// Velocity is in milli-steps per second: one step per wrap
	localparam int VEL_SCALE = 1000;
	localparam longint PULSE_WRAP = longint'(CLK_HZ) * VEL_SCALE;
	localparam int PHASE_W = 37;
	// Brake distance divisor: 2 * milli-units * milliseconds
	localparam int BRAKE_DEN = 2 * VEL_SCALE * 1000;

	////////////////////////////////////////////////////////////////////////
	// Ranges and defaults (time in ms, velocity in milli-steps/s)
	localparam logic [TIME_W-1:0] TIME_MIN_MS = 19'h00001;
	localparam logic [TIME_W-1:0] TIME_MAX_MS = 19'h7A120;
	localparam logic [TIME_W-1:0] TIME_DEF_MS = 19'h001F4;
	localparam logic [TIME_W-1:0] AUTO_RAMP_MS = 19'h000C8;
	localparam logic [VEL_W-1:0] VEL_MIN = 32'h0000_0001;
	localparam logic [VEL_W-1:0] VEL_LIMIT = 32'h0500_0000;
	localparam logic [VEL_W-1:0] RUN_VEL_DEF = 32'h0000_03E8;
	localparam logic [VEL_W-1:0] START_VEL_DEF = 32'h0000_0064;
	localparam logic [VEL_W-1:0] SLOW_VEL_DEF = 32'h0000_03E8;
	localparam logic [VEL_W-1:0] AUTO_FLOOR_VEL = 32'h0000_03E8;
	localparam logic [POS_W-1:0] POS_LIMIT = 32'h4000_0000;
	localparam logic [POS_W-1:0] STOP_DIST_DEF = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Encodings
	localparam logic KIND_ABS = 1'h0;
	localparam logic KIND_INC = 1'h1;
	localparam logic KIND_DEF = KIND_INC;
	localparam logic CHAIN_DEF = 1'h0;
	localparam logic [1:0] SENS_HARD = 2'h0;
	localparam logic [1:0] SENS_SOFT = 2'h1;
	localparam logic [1:0] SENS_SLOW = 2'h2;
	localparam logic [1:0] SENS_ACT_DEF = SENS_SLOW;
	localparam logic RAMP_LINEAR = 1'h0;
	localparam logic RAMP_AUTO = 1'h1;

	typedef enum {ST_IDLE, ST_RUN, ST_STOP} state_t;
	typedef enum {JOG_NONE, JOG_FWD, JOG_REV} jog_t;

	typedef struct packed {
		logic signed [POS_W-1:0] segment_travel;
		logic [VEL_W-1:0] segment_run_velocity;
		logic segment_position_kind;
		logic segment_chain_flag;
	} segment_t;

	typedef struct packed {
		logic [VEL_W-1:0] starting_velocity;
		logic [TIME_W-1:0] accel_time;
		logic [TIME_W-1:0] decel_time;
		logic ramp_select;
	} ramp_cfg_t;

	typedef struct packed {
		logic enable;
		logic [1:0] sensor_stop_action;
		logic [POS_W-1:0] sensor_stop_distance;
		logic [VEL_W-1:0] sensor_slow_velocity;
	} sensor_cfg_t;

endpackage

// >>> design/serial_divider.sv
// Restoring divider, one quotient bit per clock
module serial_divider #(
	parameter int W = 52
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [W-1:0] num_i,
	input wire logic [W-1:0] den_i,
	output logic [W-1:0] quo_o,
	output logic done_o
);
	logic [W-1:0] rem_ff, nxt_rem, quo_ff, nxt_quo, den_ff, nxt_den;
	logic [W:0] trial;
	logic [$clog2(W+1)-1:0] cnt_ff, nxt_cnt;
	logic done_ff, nxt_done;

	// Shift-subtract step; a start aborts any division in flight
	always_comb
	begin
		nxt_rem = rem_ff;
		nxt_quo = quo_ff;
		nxt_den = den_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		trial = {rem_ff, quo_ff[W-1]} - {1'b0, den_ff};
		if (start_i)
		begin
			nxt_rem = '0;
			nxt_quo = num_i;
			nxt_den = den_i;
			nxt_cnt = ($clog2(W+1))'(W);
		end
		else if (cnt_ff != '0)
		begin
			if (!trial[W])
			begin
				nxt_rem = trial[W-1:0];
				nxt_quo = {quo_ff[W-2:0], 1'b1};
			end
			else
			begin
				nxt_rem = {rem_ff[W-2:0], quo_ff[W-1]};
				nxt_quo = {quo_ff[W-2:0], 1'b0};
			end
			nxt_cnt = cnt_ff - 1'b1;
			nxt_done = (cnt_ff == 1'b1);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rem_ff <= '0;
			quo_ff <= '0;
			den_ff <= '0;
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end
		else
		begin
			rem_ff <= nxt_rem;
			quo_ff <= nxt_quo;
			den_ff <= nxt_den;
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign quo_o = quo_ff;
	assign done_o = done_ff;
endmodule // serial_divider

// >>> design/step_pulse_gen.sv
// Phase accumulator: one step pulse per wrap of velocity sum
module step_pulse_gen (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic [motion_pkg::VEL_W-1:0] vel_i,
	output logic step_o
);
	logic [motion_pkg::PHASE_W-1:0] acc_ff, nxt_acc;
	logic [motion_pkg::PHASE_W-1:0] sum;
	logic step_ff, nxt_step;

	// Carry the remainder so long-run rate is exact
	always_comb
	begin
		sum = acc_ff + motion_pkg::PHASE_W'(vel_i);
		nxt_step = 1'b0;
		nxt_acc = sum;
		if (clear_i)
			nxt_acc = '0;
		else if (sum >= motion_pkg::PHASE_W'(motion_pkg::PULSE_WRAP))
		begin
			nxt_acc = sum - motion_pkg::PHASE_W'(motion_pkg::PULSE_WRAP);
			nxt_step = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			acc_ff <= '0;
			step_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			step_ff <= nxt_step;
		end
	end

	assign step_o = step_ff;
endmodule // step_pulse_gen

// >>> design/motion_profile.sv
// Contract
// - Linked moves up to four segments
// - Chained segment ramps on without stopping
// - Linked start takes segment index 0-3
// - Position kind: 0 absolute, 1 incremental
// - Chain flag 0 ends, 1 continues
// - Common accel/decel times, 0.001-500 s
// - Linked moves always use linear ramps
// - Pause soft-stops linked move; resume ignored
// - Continuous move holds speed until changed
// - Jog takes running velocity at command
// - Linear jog ramp: accel up, decel down
// - Jog from rest steps to starting velocity
// - Auto ramp ignores start velocity, times; code still uses decel time for the brake distance
// - Jog direction must match previous jog
// - Sensor action 0 hard, 1 soft stop
// - Action 2: slow, stop at distance
// - Sensor distance and slow velocity ranges
// - Segment and starting velocity ranges
// - Reset clears position counter to zero
// - Successful home seeking zeroes position
// - Position write only while motor idle
// - Point move starts, ends at starting velocity
module motion_profile #(
	parameter int unsigned TICK_CYCLES = motion_pkg::TICK_CYCLES
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire motion_pkg::segment_t [motion_pkg::NUM_SEG-1:0] SEGMENTS_I,
	input wire motion_pkg::ramp_cfg_t RAMP_CFG_I,
	input wire logic [motion_pkg::VEL_W-1:0] RUNNING_VELOCITY_I,
	input wire motion_pkg::sensor_cfg_t SENSOR_CFG_I,
	input wire logic SENSOR_I,
	input wire logic LINK_START_I,
	input wire logic [1:0] LINK_SEGMENT_I,
	input wire logic JOG_FORWARD_I,
	input wire logic JOG_REVERSE_I,
	input wire logic HARD_STOP_I,
	input wire logic SOFT_STOP_I,
	input wire logic PAUSE_I,
	input wire logic RESUME_I,
	input wire logic HOME_DONE_I,
	input wire logic POSITION_WRITE_I,
	input wire logic signed [motion_pkg::POS_W-1:0] POSITION_VALUE_I,
	output logic STEP_O,
	output logic DIR_O,
	output logic MOVING_O,
	output logic CMD_REJECT_O,
	output logic signed [motion_pkg::POS_W-1:0] POSITION_O,
	output logic [motion_pkg::VEL_W-1:0] VELOCITY_O
);
	localparam int PW = motion_pkg::POS_W;
	localparam int VW = motion_pkg::VEL_W;
	localparam int TW = motion_pkg::TIME_W;
	localparam int DW = motion_pkg::DIV_W;

	////////////////////////////////////////////////////////////////////////
	// Range helpers
	function automatic logic [TW-1:0] clamp_time(input logic [TW-1:0] t);
		if (t < motion_pkg::TIME_MIN_MS)
			return motion_pkg::TIME_MIN_MS;
		if (t > motion_pkg::TIME_MAX_MS)
			return motion_pkg::TIME_MAX_MS;
		return t;
	endfunction

	function automatic logic [VW-1:0] clamp_vel(input logic [VW-1:0] v,
			input logic [VW-1:0] lo);
		if (v < lo)
			return lo;
		if (v > motion_pkg::VEL_LIMIT)
			return motion_pkg::VEL_LIMIT;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	motion_pkg::state_t state_ff, nxt_state;
	motion_pkg::jog_t jog_ff, nxt_jog;
	logic [VW-1:0] vel_ff, nxt_vel, tgt_ff, nxt_tgt, floor_ff, nxt_floor;
	logic [VW-1:0] rstep_ff, nxt_rstep, hold_ff, nxt_hold;
	logic signed [PW-1:0] pos_ff, nxt_pos, end_ff, nxt_end;
	logic [PW-1:0] brake_ff, nxt_brake;
	logic dir_ff, nxt_dir, has_end_ff, nxt_has_end, chain_ff, nxt_chain;
	logic linked_ff, nxt_linked, braking_ff, nxt_braking;
	logic paused_ff, nxt_paused, auto_ff, nxt_auto, go_ff, nxt_go;
	logic [1:0] seg_ff, nxt_seg;
	logic moving_ff, step_out_ff, reject_ff, nxt_reject;
	logic [31:0] tick_ff, nxt_tick;
	logic sens1_ff, sens2_ff, sens3_ff;

	////////////////////////////////////////////////////////////////////////
	// Working signals
	logic tick, step_pulse, sens_edge, reached, load;
	logic [1:0] load_idx;
	motion_pkg::segment_t lseg;
	logic signed [PW:0] rem;
	logic [VW:0] vsum;
	logic [VW-1:0] vs_eff, jog_vel;
	logic [TW-1:0] ramp_ms, td_ms;
	logic [DW-1:0] rdiv_num, rdiv_den, rdiv_q, bdiv_num, bdiv_q;
	logic rdiv_done, bdiv_done, jog_req, jog_dir_fwd;

	////////////////////////////////////////////////////////////////////////
	// Sensor pin synchroniser; first stage feeds only the second
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			sens1_ff <= 1'b0;
			sens2_ff <= 1'b0;
			sens3_ff <= 1'b0;
		end
		else
		begin
			sens1_ff <= SENSOR_I;
			sens2_ff <= sens1_ff;
			sens3_ff <= sens2_ff;
		end
	end
	assign sens_edge = sens2_ff & ~sens3_ff;

	////////////////////////////////////////////////////////////////////////
	// Millisecond ramp tick
	always_comb
	begin
		nxt_tick = tick_ff + 32'h0000_0001;
		tick = (tick_ff == TICK_CYCLES - 1);
		if (tick || state_ff == motion_pkg::ST_IDLE)
			nxt_tick = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Ramp step = speed gap / ramp time, computed once per target change
	always_comb
	begin
		td_ms = clamp_time(RAMP_CFG_I.decel_time);
		if (auto_ff)
			ramp_ms = motion_pkg::AUTO_RAMP_MS;
		else if (tgt_ff > vel_ff)
			ramp_ms = clamp_time(RAMP_CFG_I.accel_time);
		else
			ramp_ms = td_ms;
		rdiv_num = (tgt_ff > vel_ff) ? DW'(tgt_ff - vel_ff)
			: DW'(vel_ff - tgt_ff);
		rdiv_den = DW'(ramp_ms);
		// Distance covered decelerating linearly to the floor speed
		bdiv_num = DW'(vel_ff + floor_ff) * DW'(td_ms);
	end

	serial_divider #(.W(DW)) ramp_div (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.start_i(go_ff),
		.num_i(rdiv_num),
		.den_i(rdiv_den),
		.quo_o(rdiv_q),
		.done_o(rdiv_done)
	);

	serial_divider #(.W(DW)) brake_div (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.start_i(tick),
		.num_i(bdiv_num),
		.den_i(DW'(motion_pkg::BRAKE_DEN)),
		.quo_o(bdiv_q),
		.done_o(bdiv_done)
	);

	// Cleared on the edge into idle, so no stray step follows a stop
	step_pulse_gen pulser (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.clear_i(nxt_state == motion_pkg::ST_IDLE),
		.vel_i(vel_ff),
		.step_o(step_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Profile sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_jog = jog_ff;
		nxt_vel = vel_ff;
		nxt_tgt = tgt_ff;
		nxt_floor = floor_ff;
		nxt_rstep = rstep_ff;
		nxt_hold = hold_ff;
		nxt_pos = pos_ff;
		nxt_end = end_ff;
		nxt_brake = brake_ff;
		nxt_dir = dir_ff;
		nxt_has_end = has_end_ff;
		nxt_chain = chain_ff;
		nxt_linked = linked_ff;
		nxt_braking = braking_ff;
		nxt_paused = paused_ff;
		nxt_auto = auto_ff;
		nxt_seg = seg_ff;
		nxt_go = 1'b0;
		nxt_reject = 1'b0;
		load = 1'b0;
		load_idx = LINK_SEGMENT_I;
		vs_eff = clamp_vel(RAMP_CFG_I.starting_velocity, '0);
		jog_vel = clamp_vel(RUNNING_VELOCITY_I, motion_pkg::VEL_MIN);
		jog_req = JOG_FORWARD_I | JOG_REVERSE_I;
		jog_dir_fwd = JOG_FORWARD_I;
		rem = dir_ff ? (PW+1)'(end_ff) - (PW+1)'(pos_ff)
			: (PW+1)'(pos_ff) - (PW+1)'(end_ff);
		reached = has_end_ff && (rem <= 0);

		// Position count follows emitted steps
		if (step_pulse)
			nxt_pos = dir_ff ? pos_ff + 1'b1 : pos_ff - 1'b1;

		// Braking distance refresh
		if (bdiv_done)
			nxt_brake = (|bdiv_q[DW-1:PW]) ? '1 : bdiv_q[PW-1:0];
		if (rdiv_done)
			nxt_rstep = (rdiv_q == '0) ? VEL_MIN_STEP() : rdiv_q[VW-1:0];

		// Linear velocity ramp toward target, one step per tick
		vsum = {1'b0, vel_ff} + {1'b0, rstep_ff};
		if (tick && vel_ff < tgt_ff)
			nxt_vel = (vsum > {1'b0, tgt_ff}) ? tgt_ff : vsum[VW-1:0];
		else if (tick && vel_ff > tgt_ff)
			nxt_vel = (vel_ff - tgt_ff < rstep_ff) ? tgt_ff
				: vel_ff - rstep_ff;

		case (state_ff)
			motion_pkg::ST_IDLE:
			begin
				nxt_vel = '0;
				if (LINK_START_I)
				begin
					load = 1'b1;
					nxt_linked = 1'b1;
					nxt_paused = 1'b0;
					nxt_auto = motion_pkg::RAMP_LINEAR;
					nxt_floor = vs_eff;
					nxt_vel = vs_eff;
					nxt_state = motion_pkg::ST_RUN;
				end
				else if (jog_req && jog_ff != motion_pkg::JOG_NONE
					&& (jog_ff == motion_pkg::JOG_FWD) != jog_dir_fwd)
					nxt_reject = 1'b1;
				else if (jog_req || (RESUME_I && paused_ff && !linked_ff))
				begin
					// Resume replays the paused jog at its old speed
					nxt_dir = jog_req ? jog_dir_fwd : dir_ff;
					nxt_jog = nxt_dir ? motion_pkg::JOG_FWD
						: motion_pkg::JOG_REV;
					nxt_tgt = jog_req ? jog_vel : hold_ff;
					nxt_hold = nxt_tgt;
					nxt_auto = RAMP_CFG_I.ramp_select;
					// Auto ramp starts from rest, ignoring start speed
					nxt_vel = RAMP_CFG_I.ramp_select ? '0 : vs_eff;
					nxt_floor = RAMP_CFG_I.ramp_select
						? motion_pkg::AUTO_FLOOR_VEL : vs_eff;
					nxt_has_end = 1'b0;
					nxt_linked = 1'b0;
					nxt_paused = 1'b0;
					nxt_braking = 1'b0;
					nxt_go = 1'b1;
					nxt_state = motion_pkg::ST_RUN;
				end
				else if (POSITION_WRITE_I)
				begin
					if (POSITION_VALUE_I > $signed(motion_pkg::POS_LIMIT)
						|| POSITION_VALUE_I < -$signed(motion_pkg::POS_LIMIT))
						nxt_reject = 1'b1;
					else
						nxt_pos = POSITION_VALUE_I;
				end
			end

			motion_pkg::ST_RUN:
			begin
				if (HARD_STOP_I || (sens_edge && SENSOR_CFG_I.enable
					&& !linked_ff && !has_end_ff
					&& SENSOR_CFG_I.sensor_stop_action == motion_pkg::SENS_HARD))
				begin
					nxt_vel = '0;
					nxt_state = motion_pkg::ST_IDLE;
				end
				else if (SOFT_STOP_I || PAUSE_I || (sens_edge
					&& SENSOR_CFG_I.enable && !linked_ff && !has_end_ff
					&& SENSOR_CFG_I.sensor_stop_action == motion_pkg::SENS_SOFT))
				begin
					nxt_tgt = floor_ff;
					nxt_go = 1'b1;
					// A paused linked move cannot be continued
					nxt_paused = PAUSE_I && !linked_ff;
					nxt_state = motion_pkg::ST_STOP;
				end
				else if (reached && chain_ff)
				begin
					load = 1'b1;
					load_idx = seg_ff + 2'h1;
				end
				else if (reached)
					nxt_state = motion_pkg::ST_IDLE;
				else if (has_end_ff && !chain_ff && !braking_ff
					&& rem <= $signed({1'b0, brake_ff}))
				begin
					nxt_braking = 1'b1;
					// Never speed up to brake: a slower sensor speed stands
					nxt_tgt = (tgt_ff < floor_ff) ? tgt_ff
						: floor_ff;
					nxt_go = 1'b1;
				end
				else if (sens_edge && SENSOR_CFG_I.enable && !linked_ff
					&& !has_end_ff)
				begin
					// Slow down, then stop a fixed distance past the edge
					nxt_tgt = clamp_vel(SENSOR_CFG_I.sensor_slow_velocity,
						motion_pkg::VEL_MIN);
					nxt_end = dir_ff ? pos_ff + PW'(SENSOR_DIST())
						: pos_ff - PW'(SENSOR_DIST());
					nxt_has_end = 1'b1;
					nxt_chain = 1'b0;
					nxt_go = 1'b1;
				end
				else if (jog_req && (linked_ff || jog_dir_fwd != dir_ff))
					nxt_reject = 1'b1;
				else if (jog_req)
				begin
					nxt_tgt = jog_vel;
					nxt_hold = jog_vel;
					nxt_go = 1'b1;
				end
			end

			motion_pkg::ST_STOP:
			begin
				if (HARD_STOP_I)
				begin
					nxt_vel = '0;
					nxt_state = motion_pkg::ST_IDLE;
				end
				else if (vel_ff <= tgt_ff)
					nxt_state = motion_pkg::ST_IDLE;
			end

			default:
				nxt_state = motion_pkg::ST_IDLE;
		endcase

		// Refusal holds whichever branch wins, stopping phase too
		if (state_ff != motion_pkg::ST_IDLE && jog_req
			&& (linked_ff || jog_dir_fwd != dir_ff))
			nxt_reject = 1'b1;

		// Segment load: destination, speed and chaining from its setup
		lseg = SEGMENTS_I[load_idx];
		if (load)
		begin
			nxt_seg = load_idx;
			nxt_end = (lseg.segment_position_kind == motion_pkg::KIND_ABS)
				? lseg.segment_travel
				: pos_ff + lseg.segment_travel;
			// Direction set by the first segment only
			if (state_ff == motion_pkg::ST_IDLE)
				nxt_dir = (lseg.segment_position_kind == motion_pkg::KIND_ABS)
					? (lseg.segment_travel > pos_ff)
					: (lseg.segment_travel > 0);
			nxt_tgt = clamp_vel(lseg.segment_run_velocity,
				motion_pkg::VEL_MIN);
			nxt_chain = (load_idx != 2'h3) && lseg.segment_chain_flag;
			nxt_has_end = 1'b1;
			nxt_braking = 1'b0;
			// Hold off braking until a fresh estimate arrives
			nxt_brake = '0;
			nxt_go = 1'b1;
		end

		if (nxt_state == motion_pkg::ST_IDLE
			&& state_ff != motion_pkg::ST_IDLE)
		begin
			nxt_vel = '0;
			nxt_has_end = 1'b0;
			if (!nxt_paused)
				nxt_jog = motion_pkg::JOG_NONE;
		end

		// Home seeking done: its end point becomes electrical home
		if (HOME_DONE_I)
			nxt_pos = '0;
	end

	function automatic logic [VW-1:0] VEL_MIN_STEP();
		return motion_pkg::VEL_MIN;
	endfunction

	// Sensor stop distance clamped to the position limit
	function automatic logic [PW-1:0] SENSOR_DIST();
		if (SENSOR_CFG_I.sensor_stop_distance > motion_pkg::POS_LIMIT)
			return motion_pkg::POS_LIMIT;
		return SENSOR_CFG_I.sensor_stop_distance;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			state_ff <= motion_pkg::ST_IDLE;
			jog_ff <= motion_pkg::JOG_NONE;
			vel_ff <= '0;
			tgt_ff <= '0;
			floor_ff <= '0;
			rstep_ff <= motion_pkg::VEL_MIN;
			hold_ff <= '0;
			pos_ff <= '0;
			end_ff <= '0;
			brake_ff <= '1;
			dir_ff <= 1'b1;
			has_end_ff <= 1'b0;
			chain_ff <= 1'b0;
			linked_ff <= 1'b0;
			braking_ff <= 1'b0;
			paused_ff <= 1'b0;
			auto_ff <= motion_pkg::RAMP_LINEAR;
			go_ff <= 1'b0;
			seg_ff <= '0;
			moving_ff <= 1'b0;
			step_out_ff <= 1'b0;
			reject_ff <= 1'b0;
			tick_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			jog_ff <= nxt_jog;
			vel_ff <= nxt_vel;
			tgt_ff <= nxt_tgt;
			floor_ff <= nxt_floor;
			rstep_ff <= nxt_rstep;
			hold_ff <= nxt_hold;
			pos_ff <= nxt_pos;
			end_ff <= nxt_end;
			brake_ff <= nxt_brake;
			dir_ff <= nxt_dir;
			has_end_ff <= nxt_has_end;
			chain_ff <= nxt_chain;
			linked_ff <= nxt_linked;
			braking_ff <= nxt_braking;
			paused_ff <= nxt_paused;
			auto_ff <= nxt_auto;
			go_ff <= nxt_go;
			seg_ff <= nxt_seg;
			moving_ff <= (nxt_state != motion_pkg::ST_IDLE);
			step_out_ff <= step_pulse;
			reject_ff <= nxt_reject;
			tick_ff <= nxt_tick;
		end
	end

	assign STEP_O = step_out_ff;
	assign DIR_O = dir_ff;
	assign MOVING_O = moving_ff;
	assign CMD_REJECT_O = reject_ff;
	assign POSITION_O = pos_ff;
	assign VELOCITY_O = vel_ff;
endmodule // motion_profile

// >>> tb/motion_profile_sva.sv
// Port checker for the motion profile block
module motion_profile_sva (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire motion_pkg::ramp_cfg_t RAMP_CFG_I,
	input wire motion_pkg::sensor_cfg_t SENSOR_CFG_I,
	input wire logic SENSOR_I,
	input wire logic LINK_START_I,
	input wire logic JOG_FORWARD_I,
	input wire logic JOG_REVERSE_I,
	input wire logic HARD_STOP_I,
	input wire logic SOFT_STOP_I,
	input wire logic PAUSE_I,
	input wire logic RESUME_I,
	input wire logic HOME_DONE_I,
	input wire logic POSITION_WRITE_I,
	input wire logic signed [31:0] POSITION_VALUE_I,
	input wire logic STEP_O,
	input wire logic DIR_O,
	input wire logic MOVING_O,
	input wire logic CMD_REJECT_O,
	input wire logic signed [31:0] POSITION_O,
	input wire logic [31:0] VELOCITY_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	// Idle with no start-type command competing
	wire logic quiet = !LINK_START_I && !JOG_FORWARD_I && !JOG_REVERSE_I
		&& !RESUME_I && !MOVING_O;
	wire logic lin = RAMP_CFG_I.ramp_select == motion_pkg::RAMP_LINEAR;
	wire logic far = POSITION_VALUE_I > $signed(motion_pkg::POS_LIMIT)
		|| POSITION_VALUE_I < -$signed(motion_pkg::POS_LIMIT);
	wire logic jf = !MOVING_O && JOG_FORWARD_I && !LINK_START_I;
	wire logic calm = !HARD_STOP_I && !SOFT_STOP_I && !PAUSE_I;

	a_reset_zero: assert property ($rose(RST_N_I) |->
		POSITION_O == '0 && !MOVING_O) else $error("reset state");
	a_home_zero: assert property (quiet && HOME_DONE_I
		&& !POSITION_WRITE_I |=> POSITION_O == '0)
		else $error("home zero");
	a_write_idle: assert property (quiet && POSITION_WRITE_I
		&& !far && !HOME_DONE_I |=> POSITION_O == $past(POSITION_VALUE_I))
		else $error("position write");
	a_write_far: assert property (quiet && POSITION_WRITE_I
		&& far |=> CMD_REJECT_O) else $error("range reject");
	a_jog_start: assert property (jf && lin
		|=> MOVING_O && DIR_O
		&& VELOCITY_O == $past(RAMP_CFG_I.starting_velocity))
		else $error("jog start velocity");
	a_jog_auto: assert property (jf && !lin |=> MOVING_O
		&& VELOCITY_O == '0) else $error("auto start");
	a_rev_refuse: assert property (MOVING_O && DIR_O
		&& JOG_REVERSE_I && calm && !SENSOR_CFG_I.enable
		|=> CMD_REJECT_O) else $error("reverse jog");
	a_hard_halt: assert property (MOVING_O && HARD_STOP_I
		|=> !MOVING_O && VELOCITY_O == '0) else $error("hard stop");
	a_idle_quiet: assert property (!MOVING_O [*2] |-> !STEP_O)
		else $error("step while idle");

	// Main scenarios reached
	c_jog: cover property (jf);
	c_link: cover property (LINK_START_I && !MOVING_O);
	c_sensor: cover property (MOVING_O && $rose(SENSOR_I));
endmodule // motion_profile_sva

bind motion_profile motion_profile_sva i_motion_profile_sva (.*);

// >>> tb/drive_stage.sv
// Drive stage: counts steps in the signalled direction
module drive_stage (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic signed [31:0] count_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Direction sampled with the pulse, as a real driver latches it
	always_ff @(posedge clk_i)
		if (!rst_n_i)
			count_o <= '0;
		else if (step_i)
			count_o <= count_o + (dir_i ? 32'sh1 : -32'sh1);
endmodule // drive_stage

// >>> tb/linked_and_continuous_motion_bench.sv
module linked_and_continuous_motion_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] VS = 32'h0400_0000;
	motion_pkg::segment_t [3:0] seg;
	motion_pkg::ramp_cfg_t rc;
	motion_pkg::sensor_cfg_t sc;
	logic clk, rst_n, sens, step, dir, mov, rej;
	logic [8:0] cmd;
	logic [1:0] lseg;
	logic [31:0] rv, vel;
	logic signed [31:0] pv, pos, cnt, e, c0;
	int num_errors, cmp_count, t1, t2;

	// Short tick so ramps of 1 ms last a few dozen cycles
	motion_profile #(.TICK_CYCLES(60)) i_motion_profile (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .SEGMENTS_I(seg),
		.RAMP_CFG_I(rc), .RUNNING_VELOCITY_I(rv), .SENSOR_CFG_I(sc),
		.SENSOR_I(sens), .LINK_START_I(cmd[0]), .LINK_SEGMENT_I(lseg),
		.JOG_FORWARD_I(cmd[1]), .JOG_REVERSE_I(cmd[2]),
		.HARD_STOP_I(cmd[3]), .SOFT_STOP_I(cmd[4]), .PAUSE_I(cmd[5]),
		.RESUME_I(cmd[6]), .HOME_DONE_I(cmd[7]),
		.POSITION_WRITE_I(cmd[8]), .POSITION_VALUE_I(pv),
		.STEP_O(step), .DIR_O(dir), .MOVING_O(mov), .CMD_REJECT_O(rej),
		.POSITION_O(pos), .VELOCITY_O(vel));
	drive_stage i_drive_stage (.clk_i(clk), .rst_n_i(rst_n),
		.step_i(step), .dir_i(dir), .count_o(cnt));

	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	// Speed seen right after a jog from rest
	function automatic logic [31:0] entry_vel(input logic sel,
			input logic [31:0] vs);
		return sel ? 32'h0 : vs;
	endfunction
	// One-cycle command pulse; returns where the answer is settled
	task automatic pulse(input int k);
		@(negedge clk);
		cmd = 9'h001 << k;
		@(negedge clk);
		cmd = '0;
	endtask
	task automatic wait_idle(input int lim);
		for (int i = 0; i < lim && mov !== 1'b0; i++)
			@(negedge clk);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// Watchdog well above the expected run length
	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		final_report();
	end

	initial
	begin
		void'($urandom(31));
		rst_n = 0; sens = 0; cmd = '0; lseg = 2'h1; pv = '0;
		rv = VS;
		rc = '{VS, 19'h00001, 19'h00001, motion_pkg::RAMP_LINEAR};
		sc = '{1'h0, motion_pkg::SENS_SLOW, 32'h0000_0002, VS >> 1};
		seg = '{4{'{32'sh63, VS, motion_pkg::KIND_INC, 1'h0}}};
		repeat (20) @(negedge clk);
		rst_n = 1;
		check(pos, 32'h0);
		check(dir, 1'h1);
		// Idle write, then one past the limit
		pv = $signed($urandom_range(32'h7FFF_FFFF)) - 32'sh3FFF_FFFF;
		e = pv;
		pulse(8);
		check(pos, e);
		pv = 32'sh4000_0001;
		pulse(8);
		check(rej, 1'h1);
		check(pos, e);
		$display("position write test done");
		// Jog under both ramp kinds, refused reverse, hard stop
		for (int r = 0; r < 2; r++)
		begin
			rc.ramp_select = r[0];
			rc.starting_velocity = $urandom_range(32'h0500_0000, 1);
			rv = $urandom_range(32'h0500_0000, 1);
			pulse(1);
			check(mov, 1'h1);
			e = entry_vel(r[0], rc.starting_velocity);
			check(vel, e);
			if (r == 0)
			begin
				// Linear ramps of 1 ms settle within two ticks
				repeat (150) @(negedge clk);
				check(vel, rv);
				rv = $urandom_range(32'h0500_0000, 1);
				pulse(1);
				repeat (150) @(negedge clk);
				check(vel, rv);
			end
			pulse(2);
			check(rej, 1'h1);
			pulse(3);
			check(mov, 1'h0);
			check(vel, 32'h0);
		end
		$display("jog test done");
		// Linked move from segment 1: incremental then absolute
		rc = '{VS, 19'h00001, 19'h00001, motion_pkg::RAMP_LINEAR};
		pulse(7);
		check(pos, 32'h0);
		t1 = $urandom_range(5, 2);
		t2 = t1 + $urandom_range(5, 2);
		seg[1] = '{t1, VS, motion_pkg::KIND_INC, 1'h1};
		seg[2] = '{t2, VS, motion_pkg::KIND_ABS, 1'h0};
		c0 = cnt;
		pulse(0);
		check(mov, 1'h1);
		pulse(1);
		check(rej, 1'h1);
		wait_idle(20000);
		check(mov, 1'h0);
		check(pos, t2);
		check(cnt - c0, t2);
		// Pause ends a linked move; resume does nothing
		// Re-home first so both segments still lie ahead
		pulse(7);
		pulse(0);
		repeat (200) @(negedge clk);
		pulse(5);
		wait_idle(20000);
		pulse(6);
		repeat (3) @(negedge clk);
		check(mov, 1'h0);
		$display("linked test done");
		// Sensor actions during a forward jog
		sc.enable = 1'h1;
		rv = VS;
		for (int a = 0; a < 3; a++)
		begin
			sc.sensor_stop_action = a[1:0];
			pulse(1);
			repeat (700) @(negedge clk);
			sens = 1;
			e = pos;
			wait_idle(a == 0 ? 8 : 20000);
			check(mov, 1'h0);
			if (a == 2)
				check(pos, e + 32'sh2);
			sens = 0;
			repeat (4) @(negedge clk);
		end
		$display("sensor test done");
		final_report();
	end
endmodule // linked_and_continuous_motion_bench
